// File: core/pplc_load_core.sv
// Parallel program-load cycle decoder with its byte memory and key store.
// Assumes raw programmer pins and an AXI4-Lite master on the same clock.
//
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
module pplc_load_core import pplc_pkg::*; #(
  parameter int MEM_AW = 15
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [PPLC_AW-1:0] s_axi_awaddr,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  output logic      [1:0]         s_axi_bresp,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  input  wire logic [PPLC_AW-1:0] s_axi_araddr,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  output logic      [31:0]        s_axi_rdata,
  output logic      [1:0]         s_axi_rresp,
  input  wire logic               load_reset_pin,
  input  wire logic               program_store_enable_n,
  input  wire logic               prog_strobe_n,
  input  wire logic               external_access_pin,
  input  wire logic               vpp_present,
  input  wire logic               mode_select_hi,
  input  wire logic               mode_select_mid,
  input  wire logic               mode_select_lo,
  input  wire logic [7:0]         port1_in,
  input  wire logic [4:0]         port2_in,
  input  wire logic [1:0]         expanded_addr_hi,
  input  wire logic [7:0]         port0_in,
  output logic      [7:0]         port0_out,
  output logic                    port0_oe
);
  localparam int SYNC_W = 31;

  pplc_core_t        st_r, st_nxt;
  pplc_cycle_t       kind;
  logic [SYNC_W-1:0] pins;
  logic              s_rst, s_store_n, s_strobe_n, s_access, s_vpp;
  logic              s_hi, s_mid, s_lo;
  logic [7:0]        s_p1, s_p0;
  logic [4:0]        s_p2;
  logic [1:0]        s_xhi;
  logic              strobe_fall, range_8k, mem_we, load_mode;
  logic [MEM_AW-1:0] norm_addr, exp_addr, raw_addr, mem_addr;
  logic [7:0]        mem_rd_word;
  logic [7:0]        mem [0:(1<<MEM_AW)-1];
  logic              wr_req, wr_err, rd_err;
  logic [PPLC_AW-1:0] wr_addr, rd_addr;
  logic [31:0]       wr_data, rd_data;
  logic [3:0]        wr_strb;
  logic [16:0]       baud_info;

  // All programmer pins pass two flip-flops before any decode.
  pplc_sync #(.WIDTH(SYNC_W)) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({load_reset_pin, program_store_enable_n, prog_strobe_n,
                external_access_pin, vpp_present, mode_select_hi,
                mode_select_mid, mode_select_lo, port1_in, port2_in,
                expanded_addr_hi, port0_in}),
    .sync_out (pins)
  );

  assign {s_rst, s_store_n, s_strobe_n, s_access, s_vpp, s_hi, s_mid, s_lo,
          s_p1, s_p2, s_xhi, s_p0} = pins;

  // Register bus front end.
  pplc_axil_slave u_axil (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .wr_req        (wr_req),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_strb       (wr_strb),
    .wr_err        (wr_err),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_err        (rd_err)
  );

  // Serial loader rate table: supported flag and bit-time divisor.
  function automatic logic [16:0] pplc_baud(input logic [5:0] sel);
    logic [15:0] unit;
    logic [5:0]  mask;
    logic [15:0] cnt;
    unit = 16'h0000;
    mask = 6'h00;
    cnt  = 16'h0000;
    case (sel[2:0])
      3'h0: begin unit = `PPLC_XU_14M7; mask = `PPLC_BM_14M7; end
      3'h1: begin unit = `PPLC_XU_11M0; mask = `PPLC_BM_11M0; end
      3'h2: begin unit = `PPLC_XU_9M2;  mask = `PPLC_BM_LOW;  end
      3'h3: begin unit = `PPLC_XU_7M3;  mask = `PPLC_BM_LOW;  end
      3'h4: begin unit = `PPLC_XU_5M5;  mask = `PPLC_BM_LOW;  end
      3'h5: begin unit = `PPLC_XU_1M8;  mask = `PPLC_BM_LOW;  end
      default: ;
    endcase
    case (sel[5:3])
      3'h0: cnt = unit;
      3'h1: cnt = unit >> 2;
      3'h2: cnt = unit >> 3;
      3'h3: cnt = unit >> 5;
      3'h4: cnt = unit >> 6;
      3'h5: cnt = (unit == `PPLC_XU_11M0) ? 16'h0001 : 16'h0000;
      default: cnt = 16'h0000;
    endcase
    if (sel[5:3] > 3'h5 || !mask[sel[5:3]])
      pplc_baud = 17'h00000;
    else
      pplc_baud = {1'b1, cnt};
  endfunction : pplc_baud

  assign baud_info = pplc_baud(st_r.baud_sel);

  // Pin decode of the load cycles; anything unlisted is no operation.
  always_comb
  begin
    kind = PPLC_NONE;
    if (s_rst)
    begin
      if (s_hi && !s_store_n && s_vpp)
        kind = s_mid ? PPLC_SECSET : PPLC_PROG;
      else if (!s_hi && !s_mid && s_access && !s_vpp)
        kind = PPLC_VERIFY;
      else if (!s_hi && s_mid && !s_store_n && s_vpp)
        kind = s_lo ? PPLC_PROG_REG : PPLC_PROG_X;
      else if (!s_hi && s_mid && !s_store_n && s_access && !s_vpp && s_strobe_n)
        kind = s_lo ? PPLC_VERIFY_REG : PPLC_VERIFY_X;
    end
  end

  // Address forming; expanded cycles reach the full 32K span unless the range bit selects the 8K map.
  assign load_mode   = s_rst && !s_store_n;
  assign strobe_fall = st_r.strobe_prev && !s_strobe_n;
  assign range_8k    = (st_r.memory_control_reg[`PPLC_RANGE_BIT] == `PPLC_RANGE_8K);
  assign norm_addr   = MEM_AW'({s_p2[3:0], s_p1});
  assign exp_addr    = MEM_AW'({s_xhi, s_p2, s_p1});
  assign raw_addr    = (kind == PPLC_PROG_X || kind == PPLC_VERIFY_X) ?
                       exp_addr : norm_addr;
  assign mem_addr    = range_8k ? (raw_addr & MEM_AW'(`PPLC_MASK_8K)) : raw_addr;
  assign mem_we      = strobe_fall && st_r.load_en &&
                       (kind == PPLC_PROG || kind == PPLC_PROG_X);
  assign mem_rd_word = mem[mem_addr];

  // Byte memory; it keeps its contents across reset.
  always_ff @(posedge aclk)
  begin
    if (mem_we)
      mem[mem_addr] <= s_p0;
  end

  // Register bus read decode.
  always_comb
  begin
    rd_err  = 1'b0;
    rd_data = 32'h00000000;
    case (rd_addr)
      `PPLC_OFF_CTRL:       rd_data[0] = st_r.load_en;
      `PPLC_OFF_STATUS:
      begin
        rd_data[`PPLC_ST_LOCK]     = st_r.memory_control_reg[`PPLC_LOCK_BIT];
        rd_data[`PPLC_ST_INIT]     = st_r.init_done;
        rd_data[`PPLC_ST_LOADMODE] = load_mode;
        rd_data[`PPLC_ST_VPP]      = s_vpp;
        rd_data[`PPLC_ST_KIND_LSB +: 3] = st_r.last_kind;
      end
      `PPLC_OFF_MEM_CTL:    rd_data[7:0] = st_r.memory_control_reg;
      `PPLC_OFF_BAUD_SEL:   rd_data[5:0] = st_r.baud_sel;
      `PPLC_OFF_BAUD_DIV:   rd_data[16:0] = baud_info;
      `PPLC_OFF_PROG_COUNT: rd_data[15:0] = st_r.prog_count;
      default:              rd_err = 1'b1;
    endcase
  end

  assign wr_err = !(wr_addr inside {`PPLC_OFF_CTRL, `PPLC_OFF_STATUS,
                    `PPLC_OFF_MEM_CTL, `PPLC_OFF_BAUD_SEL, `PPLC_OFF_BAUD_DIV,
                    `PPLC_OFF_PROG_COUNT});

  // Next state: bus writes first, then pin cycles, which win on conflict.
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.strobe_prev = s_strobe_n;
    if (wr_req && wr_strb[0])
    begin
      case (wr_addr)
        `PPLC_OFF_CTRL:     st_nxt.load_en = wr_data[0];
        `PPLC_OFF_BAUD_SEL: st_nxt.baud_sel = wr_data[5:0];
        `PPLC_OFF_MEM_CTL:
        begin
          st_nxt.memory_control_reg = wr_data[7:0];
          st_nxt.memory_control_reg[`PPLC_LOCK_BIT] = wr_data[`PPLC_LOCK_BIT] ||
            st_r.memory_control_reg[`PPLC_LOCK_BIT];
        end
        default: ;
      endcase
    end
    if (strobe_fall && st_r.load_en && kind != PPLC_NONE)
    begin
      case (kind)
        PPLC_SECSET: st_nxt.memory_control_reg[`PPLC_LOCK_BIT] = 1'b1;
        PPLC_PROG_REG:
        begin
          if (s_p1 == `PPLC_ABS_MEM_CTL && s_p2 == 5'h00)
          begin
            st_nxt.memory_control_reg = s_p0;
            st_nxt.memory_control_reg[`PPLC_LOCK_BIT] = s_p0[`PPLC_LOCK_BIT] ||
              st_r.memory_control_reg[`PPLC_LOCK_BIT];
          end
          for (int k = 0; k < `PPLC_KEY_COUNT; k++)
          begin
            if (s_p1 == (`PPLC_ABS_KEY0 + 8'(k)) && s_p2 == 5'h00)
              st_nxt.key[k] = s_p0;
          end
        end
        default: ;
      endcase
      if ((kind == PPLC_PROG || kind == PPLC_SECSET) && !st_r.init_done)
      begin
        st_nxt.memory_control_reg[`PPLC_RANGE_BIT] = `PPLC_RANGE_8K;
        st_nxt.memory_control_reg[`PPLC_PA_MSB:`PPLC_PA_LSB] = `PPLC_PA_4K;
        st_nxt.init_done = 1'b1;
      end
      if (kind != PPLC_VERIFY && kind != PPLC_VERIFY_X && kind != PPLC_VERIFY_REG)
        st_nxt.prog_count = st_r.prog_count + 16'h0001;
      st_nxt.last_kind = kind;
    end
    st_nxt.p0_oe  = st_r.load_en && (kind == PPLC_VERIFY || kind == PPLC_VERIFY_X ||
                                     kind == PPLC_VERIFY_REG);
    st_nxt.p0_out = 8'h00;
    if (st_nxt.p0_oe)
      st_nxt.p0_out = (kind == PPLC_VERIFY_REG) ? st_r.memory_control_reg : mem_rd_word;
  end

  // State register; control returns to known values on reset.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r          <= '0;
      st_r.load_en  <= `PPLC_CTRL_RST;
      st_r.memory_control_reg <= `PPLC_MEM_CTL_RST;
      st_r.baud_sel <= `PPLC_BAUD_SEL_RST;
    end
    else
      st_r <= st_nxt;
  end

  assign port0_out = st_r.p0_out;
  assign port0_oe  = st_r.p0_oe;

  // Checks on the load cycles.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_prog_write: assert property (mem_we |=> mem[$past(mem_addr)] == $past(s_p0))
    else $error("program cycle did not store the byte");
  chk_verify_mem: assert property ((st_r.load_en && kind == PPLC_VERIFY) |=>
    (port0_oe && port0_out == $past(mem_rd_word)))
    else $error("verify cycle did not return the stored byte");
  chk_secset_lock: assert property ((strobe_fall && st_r.load_en && kind == PPLC_SECSET)
    |=> st_r.memory_control_reg[`PPLC_LOCK_BIT])
    else $error("security set did not lock");
  chk_expanded_addr: assert property ((mem_we && kind == PPLC_PROG_X && !range_8k)
    |-> mem_addr == exp_addr)
    else $error("expanded address wrong");
  chk_reg_no_mem: assert property (kind == PPLC_PROG_REG |-> !mem_we)
    else $error("register cycle wrote memory");
  chk_key_write: assert property ((strobe_fall && st_r.load_en && kind == PPLC_PROG_REG &&
    s_p1 == `PPLC_ABS_KEY0 && s_p2 == 5'h00) |=> st_r.key[0] == $past(s_p0))
    else $error("key byte not taken");
  chk_verify_ctl: assert property ((st_r.load_en && kind == PPLC_VERIFY_REG) |=>
    (port0_oe && port0_out == $past(st_r.memory_control_reg)))
    else $error("control verify returned wrong byte");
  chk_first_init: assert property ((strobe_fall && st_r.load_en && !st_r.init_done &&
    (kind == PPLC_PROG || kind == PPLC_SECSET)) |=> (st_r.init_done &&
    st_r.memory_control_reg[`PPLC_RANGE_BIT] == `PPLC_RANGE_8K &&
    st_r.memory_control_reg[`PPLC_PA_MSB:`PPLC_PA_LSB] == `PPLC_PA_4K))
    else $error("first strobe did not set the memory map");
  chk_lock_sticky: assert property (st_r.memory_control_reg[`PPLC_LOCK_BIT] |=>
    st_r.memory_control_reg[`PPLC_LOCK_BIT] [*2])
    else $error("security lock dropped");
  chk_baud_fast: assert property (st_r.baud_sel == 6'h29 |-> baud_info == 17'h10001)
    else $error("fast rate entry wrong");
  chk_strobe_edge: assert property (mem_we |-> $past(s_strobe_n) && !s_strobe_n)
    else $error("write without strobe edge");
  chk_vpp_write: assert property (mem_we |-> s_vpp)
    else $error("write without programming voltage");
  chk_nop_hold: assert property ((kind == PPLC_NONE && !wr_req) |=>
    ($stable(st_r.memory_control_reg) && $stable(st_r.key) && !port0_oe))
    else $error("no-operation changed state");

  cov_prog: cover property (mem_we ##1 kind == PPLC_VERIFY);
  cov_secset: cover property (strobe_fall && kind == PPLC_SECSET);
  cov_reg: cover property (strobe_fall && kind == PPLC_PROG_REG);
  cov_expanded: cover property (mem_we && kind == PPLC_PROG_X);
endmodule : pplc_load_core

// File: pkg/pplc_regs.svh
// Constants for the parallel program-load block: offsets, fields, resets.
// Assumes inclusion by the package only; holds definitions and nothing else.
`ifndef PPLC_REGS_SVH
`define PPLC_REGS_SVH
`define PPLC_OFF_CTRL       8'h00
`define PPLC_OFF_STATUS     8'h04
`define PPLC_OFF_MEM_CTL    8'h08
`define PPLC_OFF_BAUD_SEL   8'h0C
`define PPLC_OFF_BAUD_DIV   8'h10
`define PPLC_OFF_PROG_COUNT 8'h14
`define PPLC_CTRL_RST       1'h1
`define PPLC_MEM_CTL_RST    8'hF8
`define PPLC_BAUD_SEL_RST   6'h19
`define PPLC_LOCK_BIT       0
`define PPLC_RANGE_BIT      3
`define PPLC_PA_MSB         7
`define PPLC_PA_LSB         4
`define PPLC_RANGE_8K       1'h0
`define PPLC_PA_4K          4'h2
`define PPLC_MASK_8K        16'h1FFF
`define PPLC_ABS_MEM_CTL    8'hC6
`define PPLC_ABS_KEY0       8'hF0
`define PPLC_KEY_COUNT      5
`define PPLC_ST_LOCK        0
`define PPLC_ST_INIT        1
`define PPLC_ST_LOADMODE    2
`define PPLC_ST_VPP         3
`define PPLC_ST_KIND_LSB    4
`define PPLC_RESP_OKAY      2'h0
`define PPLC_RESP_SLVERR    2'h2
// Crystal rate divided by 57600 (192 clocks per bit at 300 baud).
`define PPLC_XU_14M7        16'h0100
`define PPLC_XU_11M0        16'h00C0
`define PPLC_XU_9M2         16'h00A0
`define PPLC_XU_7M3         16'h0080
`define PPLC_XU_5M5         16'h0060
`define PPLC_XU_1M8         16'h0020
// Supported baud masks, bit n for baud index n (300 up to 57600).
`define PPLC_BM_14M7        6'h1E
`define PPLC_BM_11M0        6'h3F
`define PPLC_BM_LOW         6'h0F
`endif

// File: pkg/pplc_pkg.sv
// Types shared by the parallel program-load block.
// Assumes the constants header sits beside it on the include path.
`include "pplc_regs.svh"
package pplc_pkg;
  localparam int PPLC_AW = 8;

  typedef enum logic [2:0] {
    PPLC_NONE, PPLC_PROG, PPLC_SECSET, PPLC_VERIFY,
    PPLC_PROG_X, PPLC_VERIFY_X, PPLC_PROG_REG, PPLC_VERIFY_REG
  } pplc_cycle_t;

  typedef struct packed {
    logic                           strobe_prev;
    logic                           init_done;
    logic                           load_en;
    logic [7:0]                     memory_control_reg;
    logic [`PPLC_KEY_COUNT-1:0][7:0] key;
    logic [5:0]                     baud_sel;
    logic [7:0]                     p0_out;
    logic                           p0_oe;
    logic [15:0]                    prog_count;
    pplc_cycle_t                    last_kind;
  } pplc_core_t;

  typedef struct packed {
    logic               aw_held;
    logic [PPLC_AW-1:0] awaddr;
    logic               w_held;
    logic [31:0]        wdata;
    logic [3:0]         wstrb;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               rvalid;
    logic [31:0]        rdata;
    logic [1:0]         rresp;
  } pplc_axil_t;
endpackage : pplc_pkg

// File: core/pplc_sync.sv
// Two-stage synchroniser for a bundle of pin inputs.
// Assumes every bit is an independent level from outside the clock domain.
`timescale 1ns/10ps
module pplc_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } pplc_sync_t;

  pplc_sync_t st_r, st_nxt;

  // The first stage feeds only the second stage.
  always_comb
  begin
    st_nxt.meta   = async_in;
    st_nxt.stable = st_r.meta;
  end

  // Both stages clear on reset.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign sync_out = st_r.stable;
endmodule : pplc_sync

// File: core/pplc_axil_slave.sv
// AXI4-Lite slave front end that turns bus transfers into register strobes.
// Assumes the register file decodes addresses and flags unmapped ones.
`timescale 1ns/10ps
module pplc_axil_slave import pplc_pkg::*; (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [PPLC_AW-1:0] s_axi_awaddr,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  output logic      [1:0]         s_axi_bresp,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  input  wire logic [PPLC_AW-1:0] s_axi_araddr,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  output logic      [31:0]        s_axi_rdata,
  output logic      [1:0]         s_axi_rresp,
  output logic                    wr_req,
  output logic      [PPLC_AW-1:0] wr_addr,
  output logic      [31:0]        wr_data,
  output logic      [3:0]         wr_strb,
  input  wire logic               wr_err,
  output logic      [PPLC_AW-1:0] rd_addr,
  input  wire logic [31:0]        rd_data,
  input  wire logic               rd_err
);
  pplc_axil_t st_r, st_nxt;

  // Address and data are held apart so they may arrive in either order.
  always_comb
  begin
    st_nxt        = st_r;
    s_axi_awready = !st_r.aw_held && !st_r.bvalid;
    s_axi_wready  = !st_r.w_held && !st_r.bvalid;
    s_axi_arready = !st_r.rvalid;
    wr_req        = st_r.aw_held && st_r.w_held && !st_r.bvalid;
    if (s_axi_awvalid && s_axi_awready)
    begin
      st_nxt.aw_held = 1'b1;
      st_nxt.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      st_nxt.w_held = 1'b1;
      st_nxt.wdata  = s_axi_wdata;
      st_nxt.wstrb  = s_axi_wstrb;
    end
    if (wr_req)
    begin
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      st_nxt.bresp   = wr_err ? `PPLC_RESP_SLVERR : `PPLC_RESP_OKAY;
    end
    if (st_r.bvalid && s_axi_bready)
      st_nxt.bvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = rd_err ? 32'h00000000 : rd_data;
      st_nxt.rresp  = rd_err ? `PPLC_RESP_SLVERR : `PPLC_RESP_OKAY;
    end
    if (st_r.rvalid && s_axi_rready)
      st_nxt.rvalid = 1'b0;
  end

  // Bus state register.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // Outputs straight from the held state, except rd_addr, which follows s_axi_araddr.
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp  = st_r.bresp;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata  = st_r.rdata;
  assign s_axi_rresp  = st_r.rresp;
  assign wr_addr      = st_r.awaddr;
  assign wr_data      = st_r.wdata;
  assign wr_strb      = st_r.wstrb;
  assign rd_addr      = s_axi_araddr;
endmodule : pplc_axil_slave

// File: verification/pplc_prog_model.sv
// Parallel programmer model that drives the load pins and reads port 0.
// Assumes one clock shared with the device and pins synchronised by two flops.
`timescale 1ns/10ps
module pplc_prog_model (
  input  wire logic       aclk,
  input  wire logic [7:0] port0_out,
  input  wire logic       port0_oe,
  output logic            load_reset_pin,
  output logic            program_store_enable_n,
  output logic            prog_strobe_n,
  output logic            external_access_pin,
  output logic            vpp_present,
  output logic            mode_select_hi,
  output logic            mode_select_mid,
  output logic            mode_select_lo,
  output logic [7:0]      port1_in,
  output logic [4:0]      port2_in,
  output logic [1:0]      expanded_addr_hi,
  output logic [7:0]      port0_in
);
  logic [5:0] ctl;
  logic [7:0] drv;
  // Mode pins follow one control word.
  assign {program_store_enable_n, external_access_pin, vpp_present,
          mode_select_hi, mode_select_mid, mode_select_lo} = ctl;
  // Port 0 has no pull-ups, so a released bus reads whatever the programmer leaves.
  assign port0_in = port0_oe ? port0_out : drv;
  // Idle pins match no load cycle and the strobe rests high.
  initial
  begin
    load_reset_pin = 1'b1;
    prog_strobe_n = 1'b1;
    ctl = 6'h26;
    drv = 8'hFF;
    {expanded_addr_hi, port2_in, port1_in} = 15'h0000;
  end
  // Presents one cycle, samples port 0, pulses the strobe if asked, then idles.
  task automatic cyc(input logic [5:0] c, input logic [14:0] a, input logic [7:0] d,
                     input logic p, output logic [7:0] q, output logic oe);
    @(posedge aclk);
    ctl <= c;
    {expanded_addr_hi, port2_in, port1_in} <= a;
    drv <= d;
    repeat (6) @(posedge aclk);
    q = port0_in;
    oe = port0_oe;
    if (p)
    begin
      prog_strobe_n <= 1'b0;
      repeat (4) @(posedge aclk);
      prog_strobe_n <= 1'b1;
      repeat (4) @(posedge aclk);
    end
    ctl <= 6'h26;
    drv <= 8'hFF;
    repeat (6) @(posedge aclk);
  endtask : cyc
endmodule : pplc_prog_model

// File: verification/testbench.sv
// Self-checking bench for the parallel program-load block.
// Assumes the programmer model and one 100 MHz clock.
`timescale 1ns/10ps
module testbench import pplc_pkg::*; ;
  logic aclk, aresetn, awv, awr, wv, wr, bv, bry, arv, arr, rv, rry, oe;
  logic [7:0] awa, ara, q;
  logic [31:0] wd, rd, d;
  logic [3:0] ws;
  logic [1:0] br, rr, r;
  logic load_reset_pin, program_store_enable_n, prog_strobe_n, external_access_pin;
  logic vpp_present, mode_select_hi, mode_select_mid, mode_select_lo, port0_oe;
  logic [7:0] port1_in, port0_in, port0_out;
  logic [4:0] port2_in;
  logic [1:0] expanded_addr_hi;
  int err_count, n_tests;
  pplc_load_core u_dut (.aclk, .aresetn, .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_bresp(br),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
    .s_axi_rready(rry), .s_axi_rdata(rd), .s_axi_rresp(rr), .load_reset_pin,
    .program_store_enable_n, .prog_strobe_n, .external_access_pin, .vpp_present,
    .mode_select_hi, .mode_select_mid, .mode_select_lo, .port1_in, .port2_in,
    .expanded_addr_hi, .port0_in, .port0_out, .port0_oe);
  pplc_prog_model u_prog (.aclk, .port0_out, .port0_oe, .load_reset_pin,
    .program_store_enable_n, .prog_strobe_n, .external_access_pin, .vpp_present,
    .mode_select_hi, .mode_select_mid, .mode_select_lo, .port1_in, .port2_in,
    .expanded_addr_hi, .port0_in);
  // Free-running clock.
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Bus write: each half released when taken, response kept in r.
  task axw(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    {awv, wv, bry, awa, wd, ws} <= {3'b111, a, v, 4'hF};
    do
    begin
      @(posedge aclk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
    end while (!bv);
    r = br;
    bry <= 1'b0;
  endtask : axw
  // Bus read: data kept in d, response in r.
  task axr(input logic [7:0] a);
    @(posedge aclk);
    {arv, rry, ara} <= {2'b11, a};
    do
    begin
      @(posedge aclk);
      if (arv && arr) arv <= 1'b0;
    end while (!rv);
    d = rd;
    r = rr;
    rry <= 1'b0;
  endtask : axr
  // Prints the verdict and ends the run.
  task close_out;
    if (err_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out
  // Reset values, an unmapped offset, then the serial rate table.
  task t_reset;
    axr(8'h08);
    chk(d, 32'hF8);
    axr(8'h04);
    chk(d, 32'h0);
    axr(8'h3C);
    chk(32'(r), 32'h2);
    axr(8'h10);
    chk(d, 32'h10006);
    axw(8'h0C, 32'h29);
    axr(8'h10);
    chk(d, 32'h10001);
    axw(8'h0C, 32'h28);
    axr(8'h10);
    chk(d, 32'h0);
  endtask : t_reset
  // First program strobe writes a byte and sets the 8K map with a 4K split.
  task t_prog;
    u_prog.cyc(6'h1C, 15'h0123, 8'hA5, 1'b1, q, oe);
    u_prog.cyc(6'h10, 15'h0123, 8'hFF, 1'b0, q, oe);
    chk(32'({oe, q}), 32'h1A5);
    axr(8'h08);
    chk(d, 32'h20);
    axr(8'h04);
    chk(d, 32'h12);
  endtask : t_prog
  // Control byte then a key byte by absolute address, then control verify.
  task t_reg;
    u_prog.cyc(6'h1B, 15'h00C6, 8'h28, 1'b1, q, oe);
    u_prog.cyc(6'h1B, 15'h00F0, 8'h5A, 1'b1, q, oe);
    u_prog.cyc(6'h13, 15'h00C6, 8'hFF, 1'b0, q, oe);
    chk(32'({oe, q}), 32'h128);
  endtask : t_reg
  // Expanded byte above 4K lands apart from the normal one; no re-init.
  task t_exp;
    u_prog.cyc(6'h1A, 15'h7123, 8'h3C, 1'b1, q, oe);
    u_prog.cyc(6'h12, 15'h7123, 8'hFF, 1'b0, q, oe);
    chk(32'({oe, q}), 32'h13C);
    u_prog.cyc(6'h10, 15'h0123, 8'hFF, 1'b0, q, oe);
    chk(32'(q), 32'hA5);
    axr(8'h08);
    chk(d, 32'h28);
  endtask : t_exp
  // An unlisted pin set with a strobe changes nothing and drives nothing.
  task t_noop;
    u_prog.cyc(6'h14, 15'h0123, 8'h99, 1'b1, q, oe);
    chk(32'(oe), 32'h0);
    axw(8'h00, 32'h0);
    u_prog.cyc(6'h1C, 15'h0123, 8'h77, 1'b1, q, oe);
    u_prog.cyc(6'h10, 15'h0123, 8'hFF, 1'b0, q, oe);
    chk(32'(oe), 32'h0);
    axw(8'h00, 32'h1);
    u_prog.cyc(6'h10, 15'h0123, 8'hFF, 1'b0, q, oe);
    chk(32'(q), 32'hA5);
  endtask : t_noop
  // Lock by security-set strobe, then after reset by the lock bit.
  task t_lock;
    u_prog.cyc(6'h1E, 15'h0000, 8'hFF, 1'b1, q, oe);
    axr(8'h04);
    chk(32'(d[0]), 32'h1);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    axr(8'h04);
    chk(32'(d[0]), 32'h0);
    axw(8'h08, 32'h1);
    chk(32'(r), 32'h0);
    axr(8'h04);
    chk(32'(d[0]), 32'h1);
  endtask : t_lock
  // Main sequence.
  initial
  begin
    {awv, wv, bry, arv, rry, awa, ara, wd, ws} = '0;
    err_count = 0;
    n_tests = 0;
    aresetn = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_prog();
    t_reg();
    t_exp();
    t_noop();
    t_lock();
    close_out();
  end
  // Watchdog against a hung handshake.
  initial
  begin
    repeat (20000) @(posedge aclk);
    err_count++;
    close_out();
  end
endmodule : testbench
